// ---- jtag_access_gate.sv ----
`include "jtag_access_defines.svh"

module jtag_access_gate (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic nvm_port_dedicated,
    input wire logic port_select_product_term,
    input wire logic nvm_security_lock,
    input wire logic [11:0] nvm_sector_protect,
    input wire logic dev_reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    output logic port_on,
    input wire logic [7:0] mem_rdata,
    input wire logic chip_erase_done,
    output jtag_access_pkg::mem_cmd_s mem_cmd,
    output logic cfg_clear,
    output logic locked
);

    logic [3:0] sync;
    logic tck_prev_q;
    logic enable_q;
    logic lock_q;
    logic load_q;
    logic blank_q;
    logic tdo_en_q;
    logic refused_q;
    logic [7:0] shift_q;
    logic [7:0] out_q;
    logic [3:0] bitcnt_q;
    logic [7:0] rdata_q;
    logic tdo_q;
    logic tdo_oe_n_q;
    logic port_on_q;
    logic cfg_clear_q;
    jtag_access_pkg::mem_cmd_s cmd_q;

    function automatic jtag_access_pkg::mem_op_e decode_op(
        input logic [3:0] opc
    );
        unique case (opc)
            `OPC_READ: decode_op = jtag_access_pkg::op_read;
            `OPC_PROGRAM: decode_op = jtag_access_pkg::op_program;
            `OPC_VERIFY: decode_op = jtag_access_pkg::op_verify;
            `OPC_SECTOR_ERASE: decode_op = jtag_access_pkg::op_sector_erase;
            `OPC_CHIP_ERASE: decode_op = jtag_access_pkg::op_chip_erase;
            default: decode_op = jtag_access_pkg::op_none;
        endcase
    endfunction

    // Sector numbers past the last sector count as protected.
    function automatic logic sector_blocked(
        input logic [3:0] sec,
        input logic [11:0] prot
    );
        if (sec >= `SECTOR_COUNT_W) begin
            sector_blocked = 1'b1;
        end else begin
            sector_blocked = prot[sec];
        end
    endfunction

    link_sync #(
        .W(4)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        // The reset pin goes in inverted so that the cleared synchroniser
        // reads as an idle pin and no false device reset follows release.
        .d_in({~dev_reset_n, tdi, tms, tck}),
        .d_out(sync)
    );

    wire tck_s = sync[0];
    wire tms_s = sync[1];
    wire tdi_s = sync[2];
    wire dev_reset_act = sync[3];
    wire tck_rise = tck_s & ~tck_prev_q;

    wire port_on_d = nvm_port_dedicated | enable_q
        | port_select_product_term;
    // A reset abort only applies when the nonvolatile bit does not own the
    // pins, so a dedicated port survives board resets during programming.
    wire reset_abort = dev_reset_act & ~nvm_port_dedicated;
    wire abort = ~port_on_d | reset_abort;

    wire shift_bit = tck_rise & tms_s & ~abort;
    wire frame_end = tck_rise & ~tms_s & (bitcnt_q == `CMD_BITS) & ~abort;
    wire [3:0] opc = shift_q[3:0];
    wire [3:0] sector = shift_q[7:4];
    wire jtag_access_pkg::mem_op_e op = decode_op(opc);
    wire is_enable = frame_end & (opc == `OPC_ENABLE);
    wire is_disable = frame_end & (opc == `OPC_DISABLE);
    wire mem_req = frame_end & (op != jtag_access_pkg::op_none);
    wire sec_ok = (op != jtag_access_pkg::op_sector_erase)
        | ~sector_blocked(sector, nvm_sector_protect);
    wire op_ok = lock_q ? (op == jtag_access_pkg::op_chip_erase)
        : sec_ok;
    wire accept = mem_req & tdo_en_q & op_ok;
    wire refuse = mem_req & ~accept;
    wire read_ok = accept & (op == jtag_access_pkg::op_read);
    wire [7:0] read_byte = blank_q ? `BLANK_BYTE : mem_rdata;

    wire tpe_hit = addr == `TPE_OFFSET;
    wire st_hit = addr == `STATUS_OFFSET;
    wire [7:0] tpe_view = {7'h00, enable_q};
    wire [7:0] st_view = {3'h0, blank_q, refused_q, tdo_en_q, port_on_q,
        lock_q};
    wire [7:0] rd_mux = tpe_hit ? tpe_view : (st_hit ? st_view : `DATA_ZERO);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_q <= `TPE_RESET;
        end else if (dev_reset_act) begin
            enable_q <= `TPE_RESET;
        end else if (wr & tpe_hit) begin
            enable_q <= wdata[`TPE_EN_BIT];
        end
    end

    // The lock comes up set and is loaded from the strap one cycle after
    // release, so a short reset never exposes an unlocked window.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_q <= 1'b1;
            lock_q <= `LOCK_RESET;
            blank_q <= 1'b0;
            cfg_clear_q <= 1'b0;
        end else begin
            load_q <= 1'b0;
            cfg_clear_q <= chip_erase_done;
            if (chip_erase_done) begin
                lock_q <= 1'b0;
                blank_q <= 1'b1;
            end else if (load_q) begin
                lock_q <= nvm_security_lock;
            end else if (accept & (op == jtag_access_pkg::op_program)) begin
                blank_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tck_prev_q <= 1'b0;
            shift_q <= `DATA_ZERO;
            bitcnt_q <= 4'h0;
        end else begin
            tck_prev_q <= tck_s;
            if (abort | (tck_rise & ~tms_s)) begin
                bitcnt_q <= 4'h0;
            end else if (shift_bit) begin
                shift_q <= {tdi_s, shift_q[7:1]};
                if (bitcnt_q != `CMD_BITS) begin
                    bitcnt_q <= bitcnt_q + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tdo_en_q <= 1'b0;
        end else if (abort | is_disable) begin
            tdo_en_q <= 1'b0;
        end else if (is_enable) begin
            tdo_en_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_q <= `DATA_ZERO;
        end else if (frame_end & (op == jtag_access_pkg::op_read)) begin
            out_q <= read_ok ? read_byte : `DATA_ZERO;
        end else if (shift_bit) begin
            out_q <= {1'b0, out_q[7:1]};
        end
    end

    // The refused flag is sticky until the status register is read; a new
    // refusal in the read cycle wins.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refused_q <= 1'b0;
        end else if (refuse) begin
            refused_q <= 1'b1;
        end else if (rd & st_hit) begin
            refused_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_q <= '0;
            rdata_q <= `DATA_ZERO;
            tdo_q <= 1'b0;
            tdo_oe_n_q <= 1'b1;
            port_on_q <= 1'b0;
        end else begin
            cmd_q <= {accept, op, sector};
            rdata_q <= rd ? rd_mux : `DATA_ZERO;
            tdo_q <= tdo_en_q & out_q[0];
            tdo_oe_n_q <= ~tdo_en_q;
            port_on_q <= port_on_d;
        end
    end

    assign rdata = rdata_q;
    assign tdo = tdo_q;
    assign tdo_oe_n = tdo_oe_n_q;
    assign port_on = port_on_q;
    assign mem_cmd = cmd_q;
    assign cfg_clear = cfg_clear_q;
    assign locked = lock_q;

endmodule // jtag_access_gate

// ---- jtag_access_defines.svh ----
`ifndef JTAG_ACCESS_DEFINES_SVH
`define JTAG_ACCESS_DEFINES_SVH

// Register offsets on the plain register port.
`define TPE_OFFSET 8'hC7
`define STATUS_OFFSET 8'hC8

// Field positions.
`define TPE_EN_BIT 0
`define ST_LOCK_BIT 0
`define ST_PORT_ON_BIT 1
`define ST_TDO_EN_BIT 2
`define ST_REFUSED_BIT 3
`define ST_BLANK_BIT 4

// Reset values, and the byte read back from blank memory.
`define TPE_RESET 1'b0
`define LOCK_RESET 1'b1
`define DATA_ZERO 8'h00
`define BLANK_BYTE 8'hFF

// Serial command opcodes, low nibble of the command byte.
`define OPC_ENABLE 4'h1
`define OPC_DISABLE 4'h2
`define OPC_READ 4'h3
`define OPC_PROGRAM 4'h4
`define OPC_VERIFY 4'h5
`define OPC_SECTOR_ERASE 4'h6
`define OPC_CHIP_ERASE 4'h7

// Framing and sector geometry.
`define CMD_BITS 4'h8
`define SECTOR_COUNT 12
`define SECTOR_COUNT_W 4'hC

`endif

// ---- jtag_access_pkg.sv ----
package jtag_access_pkg;

    typedef enum logic [2:0] {
        op_none,
        op_read,
        op_program,
        op_verify,
        op_sector_erase,
        op_chip_erase
    } mem_op_e;

    typedef struct packed {
        logic valid;
        mem_op_e op;
        logic [3:0] sector;
    } mem_cmd_s;

endpackage

// ---- link_sync.sv ----
module link_sync #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] d_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign d_out = sync_q;

endmodule // link_sync

// ---- jtag_access_gate_sva.sv ----
module jtag_access_gate_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic nvm_port_dedicated,
    input wire logic port_select_product_term,
    input wire logic [11:0] nvm_sector_protect,
    input wire logic dev_reset_n,
    input wire logic tdo_oe_n,
    input wire logic port_on,
    input wire logic chip_erase_done,
    input wire jtag_access_pkg::mem_cmd_s mem_cmd,
    input wire logic cfg_clear,
    input wire logic locked
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire cv = mem_cmd.valid;
    AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not idle");
    AST_EN_READ: assert property (rd && addr == 8'hC7 |=> rdata[7:1] == 7'h00)
        else $error("enable register upper bits not zero");
    AST_LOCK_CMD: assert property (cv && $past(locked) |->
        mem_cmd.op == jtag_access_pkg::op_chip_erase)
        else $error("command other than chip erase while locked");
    AST_UNLOCK: assert property (chip_erase_done |-> ##[1:2] !locked)
        else $error("lock kept after chip erase");
    AST_ERASE_CFG: assert property (chip_erase_done |=> cfg_clear)
        else $error("configuration not cleared after chip erase");
    AST_PROT: assert property (cv && mem_cmd.op == jtag_access_pkg::op_sector_erase
        |-> mem_cmd.sector < 4'hC && !nvm_sector_protect[mem_cmd.sector])
        else $error("protected sector erase issued");
    AST_PORT_ON: assert property ((nvm_port_dedicated || port_select_product_term)
        |=> port_on)
        else $error("port not switched on");
    // Six cycles cover the two-flop synchroniser plus the enable flops.
    AST_ABORT: assert property ((!dev_reset_n && !nvm_port_dedicated)[*6]
        |-> tdo_oe_n && !cv)
        else $error("port active during device reset");
    cover property (cv && mem_cmd.op == jtag_access_pkg::op_chip_erase);
    cover property (!tdo_oe_n);
    cover property (chip_erase_done ##1 cfg_clear);
endmodule // jtag_access_gate_sva

bind jtag_access_gate jtag_access_gate_sva u_jtag_access_gate_sva (.*);

// ---- jtag_prog_model.sv ----
module jtag_prog_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        tck = 1'b0;
        tms = 1'b0;
        tdi = 1'b0;
    end
    // Eight shift edges and one end edge; tck idles low between frames.
    // Data flips when unused so a stale level never passes for data.
    // Pins move off the clock edge, and tdo is taken just before each shift rise,
    // because the design moves its output a few cycles after that rise.
    task automatic frame(input logic [7:0] b, output logic [7:0] rx);
        #1;
        for (int i = 0; i <= 8; i++) begin
            tms = i < 8;
            tdi = i < 8 ? b[i] : ~tdi;
            #40;
            if (i < 8) rx[i] = tdo;
            tck = 1'b1;
            #40 tck = 1'b0;
        end
        tdi = ~tdi;
    endtask
endmodule // jtag_prog_model

// ---- tb_jtag_access_gate.sv ----
module tb_jtag_access_gate;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, chip_erase_done = 1'b0;
    logic nvm_port_dedicated = 1'b0, port_select_product_term = 1'b0;
    logic nvm_security_lock = 1'b1, dev_reset_n = 1'b1;
    logic [11:0] nvm_sector_protect = 12'h004;
    logic [7:0] addr = 8'h00, wdata = 8'h00, mem_rdata = 8'h00, rdata, m_rd;
    logic tdo, tdo_oe_n, port_on, cfg_clear, locked;
    wire logic tck, tms, tdi;
    jtag_access_pkg::mem_cmd_s mem_cmd;
    logic m_lock = 1'b1, m_ten = 1'b0, m_blank = 1'b0, m_chk = 1'b0;
    logic [7:0] q[$];
    logic [31:0] lfsr = 32'h0000_4d62;
    int err_total = 0, cmp_count = 0;
    wire logic tdo_line = tdo_oe_n ? ~tdo : tdo;
    wire logic abort = !dev_reset_n && !nvm_port_dedicated;
    always #5 clk = ~clk;
    jtag_access_gate u_jtag_access_gate (.*);
    jtag_prog_model u_jtag_prog_model (.tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo_line));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] v);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic send(input logic [7:0] b);
        logic [7:0] rx, e;
        logic ok;
        logic [3:0] o;
        e = m_rd;
        o = b[3:0];
        lfsr = lfsr_next(lfsr);
        @(posedge clk);
        mem_rdata <= lfsr[7:0];
        ok = m_ten && !abort && (!m_lock || o == 4'h7) && o > 4'h2 && o < 4'h8
            && !(o == 4'h6 && (b[7:4] > 4'hB || nvm_sector_protect[b[7:4]]));
        m_rd = !ok ? 8'h00 : m_blank ? 8'hFF : lfsr[7:0];
        if (ok) q.push_back({1'b0, 3'(o - 4'h2), b[7:4]});
        if (ok && o == 4'h4) m_blank = 1'b0;
        u_jtag_prog_model.frame(b, rx);
        if (m_chk) chk("tdo byte", e, rx);
        m_chk = o == 4'h3 && m_ten && !abort;
        if (o == 4'h1 && !abort) m_ten = 1'b1;
        if (o == 4'h2 || abort) m_ten = 1'b0;
        repeat (4) @(posedge clk);
        chk("pending", 8'h00, 8'(q.size()));
    endtask
    always @(posedge clk) begin
        if (mem_cmd.valid === 1'b1) begin
            chk("mem_cmd", q.size() ? q[0] : 8'hEE,
                {1'b0, mem_cmd.op, mem_cmd.sector});
            if (q.size()) void'(q.pop_front());
        end
    end
    task automatic final_report;
        $display("checks %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #200_000;
        err_total++;
        final_report;
    end
    initial begin
        logic [7:0] v;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus(1'b1, 8'hC7, {7'h00, lfsr[3]}, v);
        bus(1'b0, 8'hC7, 8'h00, v);
        chk("enable reg", {7'h00, lfsr[3]}, v);
        bus(1'b1, 8'hC7, 8'h01, v);
        bus(1'b0, 8'h10, 8'h00, v);
        chk("unmapped", 8'h00, v);
        bus(1'b0, 8'hC8, 8'h00, v);
        chk("status", 8'h03, v & 8'h13);
        send(8'h01);
        for (int k = 3; k < 8; k++) send(8'(k));
        @(posedge clk);
        chip_erase_done <= 1'b1;
        @(posedge clk);
        chip_erase_done <= 1'b0;
        {m_lock, m_blank} = 2'b01;
        bus(1'b0, 8'hC8, 8'h00, v);
        chk("status", 8'h12, v & 8'h13);
        send(8'h03);
        send(8'h26);
        send(8'h36);
        send(8'hC6);
        bus(1'b0, 8'hC8, 8'h00, v);
        chk("refused", 8'h08, v & 8'h08);
        send(8'h04);
        send(8'h03);
        send(8'h02);
        send(8'h05);
        send(8'h01);
        dev_reset_n <= 1'b0;
        send(8'h03);
        bus(1'b0, 8'hC7, 8'h00, v);
        chk("enable reg", 8'h00, v);
        dev_reset_n <= 1'b1;
        nvm_port_dedicated <= 1'b1;
        port_select_product_term <= 1'b1;
        send(8'h01);
        dev_reset_n <= 1'b0;
        send(8'h33);
        send(8'h05);
        final_report;
    end
endmodule // tb_jtag_access_gate
